// ### psr_consts.vh
`ifndef PSR_CONSTS_VH
`define PSR_CONSTS_VH
// ==========================================
// ==========================================
`define PSR_ADDR_W 24
`define PSR_DATA_W 16
`define PSR_PORT_W 8
`define PSR_NPORT 8
`define PSR_APB_CTRL 12'h000
`define PSR_APB_STAT 12'h004
`define PSR_APB_DDR0 12'h010
`define PSR_APB_DDR_LAST 12'h02C
`define PSR_BIT_SWSTBY 0
`define PSR_BIT_SLEEP 1
`define PSR_BIT_INTERNAL_RAM_ENABLE 2
`define PSR_BIT_BUS_RELEASE_ENABLE 3
`define PSR_BIT_REFRESH_ENABLE 4
`define PSR_CTRL_RESET 32'h00000004
// Access states
`define PSR_ST_IDLE 3'h0
`define PSR_ST_T1 3'h1
`define PSR_ST_T2 3'h2
`define PSR_ST_TW 3'h3
`define PSR_ST_T3 3'h4
`define PSR_WAIT_PIN 0
`endif

// ### psr_pin_sequencer.v
`include "psr_consts.vh"
module psr_pin_sequencer (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire system_clear_input_n,
   input wire standby_input_n,
   input wire bus_request_in_n,
   input wire [2:0] access_state,
   input wire two_state_area,
   input wire access_valid,
   input wire [`PSR_ADDR_W-1:0] core_addr,
   input wire [`PSR_DATA_W-1:0] core_wdata,
   input wire core_data_drive,
   input wire core_as_n,
   input wire core_rd_n,
   input wire core_hwr_n,
   input wire core_lwr_n,
   input wire [`PSR_NPORT*`PSR_PORT_W-1:0] port_data,
   output reg clk_out_val,
   output reg clk_out_oe,
   output reg [`PSR_ADDR_W-1:0] addr_out,
   output reg addr_oe,
   output reg [`PSR_DATA_W-1:0] data_out,
   output reg data_oe,
   output reg address_strobe,
   output reg read_strobe,
   output reg upper_write_strobe,
   output reg lower_write_strobe,
   output reg strobe_oe,
   output reg bus_grant_n,
   output reg bus_grant_oe,
   output reg [`PSR_NPORT*`PSR_PORT_W-1:0] port_out,
   output reg [`PSR_NPORT*`PSR_PORT_W-1:0] port_oe,
   output reg chip_clear
);
// ==========================================
// Input synchronisers (clear sampled on falling edge)
reg clr_s1_reg, clr_s2_reg, clr_n_reg;
always @(negedge pclk or negedge presetn) begin
   if (!presetn) begin
      clr_s1_reg <= 1'b1;
      clr_s2_reg <= 1'b1;
   end else begin
      clr_s1_reg <= system_clear_input_n;
      clr_s2_reg <= clr_s1_reg;
   end
end
always @(posedge pclk or negedge presetn) begin
   if (!presetn) clr_n_reg <= 1'b1;
   else clr_n_reg <= clr_s2_reg;
end
reg stb_s1_reg, stb_n_reg, brq_s1_reg, brq_n_reg;
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      stb_s1_reg <= 1'b1;
      stb_n_reg <= 1'b1;
      brq_s1_reg <= 1'b1;
      brq_n_reg <= 1'b1;
   end else begin
      stb_s1_reg <= standby_input_n;
      stb_n_reg <= stb_s1_reg;
      brq_s1_reg <= bus_request_in_n;
      brq_n_reg <= brq_s1_reg;
   end
end
// ==========================================
// Register file
reg [31:0] system_control_reg;
reg [`PSR_PORT_W-1:0] ddr_reg [0:`PSR_NPORT-1];
wire acc = psel && penable;
// DDR window decode, one aligned word per port
wire [11:0] ddr_off = paddr - `PSR_APB_DDR0;
wire [2:0] ddr_idx = ddr_off[4:2];
wire ddr_in_range = (paddr >= `PSR_APB_DDR0) && (paddr <= `PSR_APB_DDR_LAST);
wire ddr_aligned = (paddr[1:0] == 2'b00);
wire ddr_hit = ddr_in_range && ddr_aligned;
wire ctrl_hit = (paddr == `PSR_APB_CTRL);
wire stat_hit = (paddr == `PSR_APB_STAT);
integer i;
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      system_control_reg <= `PSR_CTRL_RESET;
      for (i = 0; i < `PSR_NPORT; i = i + 1) ddr_reg[i] <= 8'h00;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
   end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(ctrl_hit || stat_hit || ddr_hit);
      prdata <= 32'h00000000;
      if (!clr_n_reg) begin
         for (i = 0; i < `PSR_NPORT; i = i + 1) ddr_reg[i] <= 8'h00;
      end else if (acc && pready && pwrite) begin
         if (ctrl_hit) system_control_reg <= {27'h0, pwdata[4:0]};
         if (ddr_hit) ddr_reg[ddr_idx] <= pwdata[7:0];
      end
      if (psel && !penable && !pwrite) begin
         if (ctrl_hit) prdata <= system_control_reg;
         if (stat_hit) prdata <= {26'h0, ~brq_n_reg, ~stb_n_reg, ~clr_n_reg, access_state};
         if (ddr_hit) prdata <= {24'h0, ddr_reg[ddr_idx]};
      end
   end
end
// ==========================================
// Mode decode
wire sw_standby_input = system_control_reg[`PSR_BIT_SWSTBY];
wire bus_release_enable = system_control_reg[`PSR_BIT_BUS_RELEASE_ENABLE];
wire hw_standby_input = !stb_n_reg;
wire bus_rel = bus_release_enable && !brq_n_reg && !sw_standby_input;
// ==========================================
// Address hold on clear
reg hold_addr_reg;
reg [`PSR_ADDR_W-1:0] last_addr_reg;
wire in_t3 = access_valid && ((access_state == `PSR_ST_T3) ||
             (two_state_area && access_state == `PSR_ST_T2));
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      hold_addr_reg <= 1'b0;
      last_addr_reg <= 24'h000000;
   end else begin
      if (clr_n_reg) last_addr_reg <= core_addr;
      if (clr_n_reg && !clr_s2_reg) begin
         hold_addr_reg <= in_t3;
      end else begin
         // Hold lasts one clock, then the address goes low
         hold_addr_reg <= 1'b0;
      end
   end
end
// ==========================================
// Pin drivers
// Port direction per mode
genvar g;
generate
   for (g = 0; g < `PSR_NPORT; g = g + 1) begin : gen_port
      always @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            port_out[g*8 +: 8] <= 8'h00;
            port_oe[g*8 +: 8] <= 8'h00;
         end else if (!clr_n_reg || hw_standby_input) begin
            port_oe[g*8 +: 8] <= 8'h00;
         end else if (sw_standby_input) begin
            port_oe[g*8 +: 8] <= ddr_reg[g];
         end else begin
            port_out[g*8 +: 8] <= port_data[g*8 +: 8];
            port_oe[g*8 +: 8] <= (g == 0) ? (ddr_reg[g] & 8'hFE) : ddr_reg[g];
         end
      end
   end
endgenerate
// Bus, strobe and clock pins
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      clk_out_val <= 1'b0;
      clk_out_oe <= 1'b0;
      addr_out <= 24'h000000;
      addr_oe <= 1'b0;
      data_out <= 16'h0000;
      data_oe <= 1'b0;
      address_strobe <= 1'b1;
      read_strobe <= 1'b1;
      upper_write_strobe <= 1'b1;
      lower_write_strobe <= 1'b1;
      strobe_oe <= 1'b0;
      bus_grant_n <= 1'b1;
      bus_grant_oe <= 1'b0;
      chip_clear <= 1'b1;
   end else begin
      chip_clear <= !clr_n_reg;
      clk_out_val <= ~clk_out_val;
      clk_out_oe <= 1'b1;
      bus_grant_n <= 1'b1;
      bus_grant_oe <= bus_release_enable;
      if (hw_standby_input) begin
         clk_out_oe <= 1'b0;
         addr_oe <= 1'b0;
         data_oe <= 1'b0;
         strobe_oe <= 1'b0;
         bus_grant_oe <= 1'b0;
      end else if (!clr_n_reg) begin
         address_strobe <= 1'b1;
         read_strobe <= 1'b1;
         upper_write_strobe <= 1'b1;
         lower_write_strobe <= 1'b1;
         strobe_oe <= 1'b1;
         data_oe <= 1'b0;
         addr_oe <= 1'b1;
         if (!hold_addr_reg) addr_out <= 24'h000000;
         else addr_out <= last_addr_reg;
      end else if (sw_standby_input) begin
         clk_out_val <= 1'b1;
         addr_oe <= 1'b0;
         data_oe <= 1'b0;
         strobe_oe <= 1'b0;
      end else if (bus_rel) begin
         addr_oe <= 1'b0;
         data_oe <= 1'b0;
         strobe_oe <= 1'b0;
         bus_grant_n <= 1'b0;
      end else begin
         addr_out <= core_addr;
         addr_oe <= 1'b1;
         data_out <= core_wdata;
         data_oe <= core_data_drive;
         address_strobe <= core_as_n;
         read_strobe <= core_rd_n;
         upper_write_strobe <= core_hwr_n;
         lower_write_strobe <= core_lwr_n;
         strobe_oe <= 1'b1;
      end
   end
end
endmodule // psr_pin_sequencer

// ### psr_partner.sv
// ==========
// Bus cycle model
module psr_partner(
   input wire logic pclk, system_clear_input_n, two_state_area,
   output logic [2:0] access_state = 3'h1,
   output logic [23:0] core_addr = 24'h000100,
   output logic access_valid, core_as_n, core_rd_n
);
   timeunit 1ns;
   timeprecision 1ps;
   assign access_valid = 1'b1;
   assign core_as_n = 1'b0;
   assign core_rd_n = 1'b0;
   // Cycle stalls while clear is low, so the state seen at sampling is fixed
   always @(posedge pclk) begin
      if (system_clear_input_n) begin
         access_state <= (access_state == 3'h4 || (two_state_area && access_state == 3'h2)) ? 3'h1 : access_state + 3'h1;
         core_addr <= core_addr + 24'h000010;
      end
   end
endmodule // psr_partner

// ### psr_pin_sequencer_checker.sv
// ==========
// Pin state checks
module psr_chk(
   input wire logic pclk, presetn, psel, penable, pready, system_clear_input_n, standby_input_n, chip_clear,
   input wire logic addr_oe, data_oe, strobe_oe, clk_out_oe, bus_grant_n, bus_grant_oe,
   input wire logic address_strobe, read_strobe, upper_write_strobe, lower_write_strobe,
   input wire logic [23:0] addr_out,
   input wire logic [63:0] port_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_set; !system_clear_input_n [*5] |-> chip_clear; endproperty
   property p_rel; system_clear_input_n [*6] |-> !chip_clear; endproperty
   property p_port; chip_clear [*3] |-> port_oe == 64'h0; endproperty
   property p_strb; (chip_clear && standby_input_n) [*5] |-> strobe_oe && address_strobe && read_strobe
      && upper_write_strobe && lower_write_strobe && !data_oe; endproperty
   property p_addr; $rose(chip_clear) && standby_input_n |-> ##[0:4] (addr_oe && addr_out == 24'h0); endproperty
   property p_hw; !standby_input_n [*5] |-> !(clk_out_oe | addr_oe | data_oe | strobe_oe | bus_grant_oe)
      && port_oe == 64'h0; endproperty
   property p_brel; bus_grant_oe && !bus_grant_n |-> clk_out_oe && !addr_oe && !data_oe && !strobe_oe; endproperty
   property p_rdy; psel && !penable |=> pready; endproperty
   a_set: assert property (p_set) else $error("clear not taken");
   a_rel: assert property (p_rel) else $error("clear stuck");
   a_port: assert property (p_port) else $error("port driven in clear");
   a_strb: assert property (p_strb) else $error("strobes wrong in clear");
   a_addr: assert property (p_addr) else $error("address not low");
   a_hw: assert property (p_hw) else $error("pin driven in standby");
   a_brel: assert property (p_brel) else $error("bus not released");
   a_rdy: assert property (p_rdy) else $error("no ready");
   c_clr: cover property ($rose(chip_clear));
   c_hw: cover property (!standby_input_n [*5]);
   c_brel: cover property (bus_grant_oe && !bus_grant_n);
endmodule // psr_chk
bind psr_pin_sequencer psr_chk CHK (.*);

// ### psr_pin_sequencer_tb.sv
// ==========
// Testbench
module psr_pin_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, chip_clear, err;
   logic system_clear_input_n = 1, standby_input_n = 1, bus_request_in_n = 1, two_state_area = 0, access_valid;
   logic core_as_n, core_rd_n, clk_out_val, clk_out_oe, addr_oe, data_oe, address_strobe, read_strobe;
   logic upper_write_strobe, lower_write_strobe, strobe_oe, bus_grant_n, bus_grant_oe;
   logic core_data_drive = 1, core_hwr_n = 1, core_lwr_n = 1;
   logic [2:0] access_state;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [23:0] core_addr, addr_out;
   logic [15:0] core_wdata = 16'h5AC3, data_out;
   logic [63:0] port_data = 64'hA5A5A5A5A5A5A5A5, port_out, port_oe;
   int num_errors = 0, cmp_count = 0, z, z1;
   psr_pin_sequencer DUT (.*);
   psr_partner BRD (.*);
   initial forever #2 pclk = ~pclk;
   task automatic wrap_up;
      if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk) penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata; err = pslverr; psel <= 0; penable <= 0;
      @(posedge pclk);
   endtask
   task automatic t_regs;
      apb(0, 12'h000, 0); chk(rd, 32'h4);
      apb(1, 12'h014, 32'hFF); apb(0, 12'h014, 0); chk(rd, 32'hFF);
      apb(0, 12'h0FC, 0); chk({err, rd}, 33'h100000000);
   endtask
   task automatic t_clr(input logic [2:0] pre, input logic tw, output int n);
      n = 0; two_state_area <= tw;
      repeat (4) @(posedge pclk);
      do @(posedge pclk); while (access_state !== pre);
      system_clear_input_n <= 0;
      repeat (8) begin @(posedge pclk); n += (addr_out === 24'h0); end
      chk(port_oe, 0);
      chk({strobe_oe, address_strobe, read_strobe, upper_write_strobe, lower_write_strobe, data_oe}, 6'h3E);
      system_clear_input_n <= 1; repeat (8) @(posedge pclk);
   endtask
   task automatic t_mode(input logic [31:0] ctl, input logic req, input logic tog, input logic [63:0] exp);
      apb(1, 12'h014, 32'hFF); apb(1, 12'h000, ctl); bus_request_in_n <= req;
      repeat (6) @(posedge pclk);
      chk({clk_out_oe, addr_oe, data_oe, strobe_oe, bus_grant_oe, bus_grant_n, port_oe[15:8]}, exp);
      z = clk_out_val; @(posedge pclk);
      chk({clk_out_val ^ z[0], clk_out_val | tog}, {tog, 1'b1});
      bus_request_in_n <= 1; apb(1, 12'h000, 32'h4);
      repeat (4) @(posedge pclk);
      chk({data_oe, data_out, address_strobe, port_out[15:8]}, {1'b1, 16'h5AC3, 1'b0, 8'hA5});
   endtask
   task automatic t_hw(input logic internal_ram_enable);
      apb(1, 12'h000, {29'h0, internal_ram_enable, 2'h0}); system_clear_input_n <= !internal_ram_enable;
      repeat (10) @(posedge pclk); standby_input_n <= 0;
      repeat (8) @(posedge pclk); system_clear_input_n <= 0;
      chk({clk_out_oe, addr_oe, data_oe, strobe_oe, bus_grant_oe, port_oe}, 0);
      repeat (25) @(posedge pclk); standby_input_n <= 1;
      repeat (8) @(posedge pclk); system_clear_input_n <= 1; repeat (8) @(posedge pclk);
   endtask
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1; @(posedge pclk);
      t_regs;
      t_clr(3'h4, 0, z1); chk(z1, 5);
      t_clr(3'h1, 0, z); chk(z, z1);
      t_clr(3'h2, 0, z); chk(z, z1);
      t_clr(3'h3, 0, z); chk(z, z1 - 1);
      t_clr(3'h1, 1, z); chk(z, z1 - 1);
      t_mode(32'h5, 1, 0, {6'h21, 8'hFF});
      t_mode(32'hC, 0, 1, {6'h22, 8'hFF});
      t_hw(1); t_hw(0);
      wrap_up;
   end
   initial begin
      #20000;
      num_errors++;
      wrap_up;
   end
endmodule // psr_pin_sequencer_tb
